// ===== rtl/tpi_tuner_pll_i2c.v
// Serial-bus programming slave of a tuner synthesizer with decoded settings outputs
`timescale 1ns/1ps
`include "tpi_consts.vh"
module tpi_tuner_pll_i2c (
	input wire mclk,
	input wire reset,
	input wire scl_in,
	input wire sda_in,
	output reg sda_out_q,
	output reg sda_oe_q,
	input wire [1:0] address_sel_bits,
	input wire pll_locked,
	input wire gain_active,
	input wire [2:0] adc_level_bits,
	output reg [14:0] divider_ratio_q,
	output reg pump_current_sel_q,
	output reg pump_hiz_q,
	output reg freq_test_q,
	output reg [7:0] ref_ratio_q,
	output reg tuning_output_disable_q,
	output reg [3:0] high_side_oe_q,
	output reg [3:0] low_side_oe_q,
	output reg [1:0] band_sel_q,
	output reg gain_loop_speed_bit_q,
	output reg [7:0] takeover_dbuv_q,
	output reg gain_detector_off_q,
	output reg gain_output_hiz_q,
	output reg gain_fast_source_q
);
	localparam ST_IDLE = 3'h0;
	localparam ST_ADDR = 3'h1;
	localparam ST_ACK = 3'h2;
	localparam ST_WDATA = 3'h3;
	localparam ST_RDATA = 3'h4;
	localparam ST_RACK = 3'h5;
	localparam ST_SKIP = 3'h6;

	// Byte roles within a write telegram
	localparam EXP_ANY = 2'h0;
	localparam EXP_DIVLO = 2'h1;
	localparam EXP_PORT = 2'h2;
	localparam EXP_GAIN = 2'h3;

	wire scl_lvl;
	wire scl_rise;
	wire scl_fall;
	wire sda_lvl;
	wire sda_rise;
	wire sda_fall;
	reg [2:0] state_q;
	reg [7:0] shift_q;
	reg [3:0] bit_cnt_q;
	reg is_read_q;
	reg addr_phase_q;
	reg ack_drive_q;
	reg [1:0] expect_q;
	reg [6:0] div_high_q;
	reg [7:0] loop_control_q;
	reg [7:0] port_switch_q;
	reg [7:0] gain_settings_q;
	reg por_flag_q;
	reg por_sent_q;
	reg [7:0] status_q;
	reg [2:0] adc_stable_q;
	reg [2:0] adc_prev_q;
	reg [2:0] lvl_meta_q;
	reg [2:0] lvl_sync_q;
	reg [2:0] adc_meta_q;
	reg [2:0] adc_sync_q;

	////////////////////////////////////////////////////////////////
	// Pin sampling
	tpi_sync u_scl (
		.mclk(mclk),
		.reset(reset),
		.async_in(scl_in),
		.level_q(scl_lvl),
		.rise_q(scl_rise),
		.fall_q(scl_fall)
	);

	tpi_sync u_sda (
		.mclk(mclk),
		.reset(reset),
		.async_in(sda_in),
		.level_q(sda_lvl),
		.rise_q(sda_rise),
		.fall_q(sda_fall)
	);

	wire start_cond = sda_fall & scl_lvl;
	wire stop_cond = sda_rise & scl_lvl;

	// Status sources come from analog circuits, so synchronise them
	always @(posedge mclk) begin
		if (reset) begin
			lvl_meta_q <= 3'h0;
			lvl_sync_q <= 3'h0;
			adc_meta_q <= 3'h0;
			adc_sync_q <= 3'h0;
			adc_prev_q <= 3'h0;
			adc_stable_q <= 3'h0;
		end else begin
			lvl_meta_q <= {pll_locked, gain_active, 1'b0};
			lvl_sync_q <= lvl_meta_q;
			adc_meta_q <= adc_level_bits;
			adc_sync_q <= adc_meta_q;
			adc_prev_q <= adc_sync_q;
			// Code taken only when steady two samples and in range; hides transition glitches
			if (adc_sync_q == adc_prev_q && adc_sync_q <= `TPI_ADC_MAX)
				adc_stable_q <= adc_sync_q;
		end
	end

	////////////////////////////////////////////////////////////////
	// Decode helpers
	function [7:0] ref_ratio;
		input [1:0] sel;
		begin
			case (sel)
				2'h0: ref_ratio = `TPI_REF_80;
				2'h1: ref_ratio = `TPI_REF_128;
				2'h2: ref_ratio = `TPI_REF_24;
				default: ref_ratio = `TPI_REF_64;
			endcase
		end
	endfunction

	function [7:0] takeover;
		input [2:0] code;
		begin
			case (code)
				3'h0, 3'h1: takeover = `TPI_TOP_115;
				3'h2: takeover = `TPI_TOP_112;
				3'h3: takeover = `TPI_TOP_109;
				3'h4: takeover = `TPI_TOP_106;
				3'h5: takeover = `TPI_TOP_103;
				default: takeover = 8'h00;
			endcase
		end
	endfunction

	function [1:0] band;
		input [1:0] p;
		begin
			case (p)
				2'h1: band = `TPI_BAND_LOW;
				2'h2: band = `TPI_BAND_MID;
				default: band = `TPI_BAND_HIGH;
			endcase
		end
	endfunction

	////////////////////////////////////////////////////////////////
	// Bus protocol engine
	always @(posedge mclk) begin
		if (reset) begin
			state_q <= ST_IDLE;
			shift_q <= 8'h00;
			bit_cnt_q <= 4'h0;
			is_read_q <= 1'b0;
			addr_phase_q <= 1'b0;
			ack_drive_q <= 1'b0;
			expect_q <= EXP_ANY;
			div_high_q <= 7'h00;
			divider_ratio_q <= 15'h0000;
			loop_control_q <= `TPI_CTRL_RESET;
			port_switch_q <= `TPI_PORT_RESET;
			gain_settings_q <= `TPI_GAIN_RESET;
			por_flag_q <= 1'b1;
			por_sent_q <= 1'b0;
			status_q <= 8'h00;
			sda_out_q <= 1'b1;
			sda_oe_q <= 1'b0;
		end else if (start_cond) begin
			state_q <= ST_ADDR;
			bit_cnt_q <= 4'h0;
			expect_q <= EXP_ANY;
			sda_oe_q <= 1'b0;
		end else if (stop_cond) begin
			state_q <= ST_IDLE;
			sda_oe_q <= 1'b0;
		end else begin
			case (state_q)
				ST_ADDR, ST_WDATA: begin
					if (scl_rise) begin
						shift_q <= {shift_q[6:0], sda_lvl};
						bit_cnt_q <= bit_cnt_q + 4'h1;
					end else if (scl_fall && bit_cnt_q == 4'h8) begin
						bit_cnt_q <= 4'h0;
						state_q <= ST_ACK;
						addr_phase_q <= (state_q == ST_ADDR);
						ack_drive_q <= 1'b1;
						if (state_q == ST_ADDR) begin
							if (shift_q[7:3] == `TPI_ADDR_FIXED && shift_q[2:1] == address_sel_bits) begin
								is_read_q <= shift_q[0];
								sda_out_q <= 1'b0;
								sda_oe_q <= 1'b1;
							end else begin
								ack_drive_q <= 1'b0;
								state_q <= ST_SKIP;
							end
						end else begin
							sda_out_q <= 1'b0;
							sda_oe_q <= 1'b1;
							case (expect_q)
								EXP_DIVLO: begin
									divider_ratio_q <= {div_high_q, shift_q};
									expect_q <= EXP_ANY;
								end
								EXP_PORT: begin
									port_switch_q <= shift_q;
									expect_q <= EXP_ANY;
								end
								EXP_GAIN: begin
									gain_settings_q <= shift_q;
									expect_q <= EXP_ANY;
								end
								default: begin
									if (!shift_q[7]) begin
										div_high_q <= shift_q[6:0];
										expect_q <= EXP_DIVLO;
									end else begin
										loop_control_q <= shift_q;
										expect_q <= (shift_q[5:3] == `TPI_TEST_AUX) ? EXP_GAIN : EXP_PORT;
									end
								end
							endcase
						end
					end
				end
				ST_ACK: begin
					if (scl_fall) begin
						sda_oe_q <= 1'b0;
						sda_out_q <= 1'b1;
						if (addr_phase_q && is_read_q) begin
							status_q <= {por_flag_q, lvl_sync_q[2], 2'h3, lvl_sync_q[1], adc_stable_q};
							state_q <= ST_RDATA;
							sda_oe_q <= ~por_flag_q | 1'b0;
							sda_out_q <= por_flag_q;
							por_sent_q <= por_flag_q;
						end else begin
							state_q <= ST_WDATA;
						end
					end
				end
				ST_RDATA: begin
					// Open-drain: drive only zeros
					if (scl_fall) begin
						bit_cnt_q <= bit_cnt_q + 4'h1;
						if (bit_cnt_q == 4'h7) begin
							sda_oe_q <= 1'b0;
							sda_out_q <= 1'b1;
							state_q <= ST_RACK;
							bit_cnt_q <= 4'h0;
						end else begin
							sda_out_q <= status_q[3'h6 - bit_cnt_q[2:0]];
							sda_oe_q <= ~status_q[3'h6 - bit_cnt_q[2:0]];
						end
					end
				end
				ST_RACK: begin
					if (scl_rise) begin
						if (por_sent_q)
							por_flag_q <= 1'b0;
						por_sent_q <= 1'b0;
						// Master ack asks for a repeat of the status byte
						if (!sda_lvl) begin
							status_q <= {1'b0, lvl_sync_q[2], 2'h3, lvl_sync_q[1], adc_stable_q};
							state_q <= ST_ACK;
							addr_phase_q <= 1'b1;
						end else begin
							state_q <= ST_SKIP;
						end
					end
				end
				default: begin
					sda_oe_q <= 1'b0;
				end
			endcase
		end
	end

	////////////////////////////////////////////////////////////////
	// Decoded settings; registered so every output is a flip-flop
	always @(posedge mclk) begin
		if (reset) begin
			pump_current_sel_q <= 1'b1;
			pump_hiz_q <= 1'b0;
			freq_test_q <= 1'b0;
			ref_ratio_q <= `TPI_REF_80;
			tuning_output_disable_q <= 1'b1;
			high_side_oe_q <= 4'h0;
			low_side_oe_q <= 4'h0;
			band_sel_q <= `TPI_BAND_HIGH;
			gain_loop_speed_bit_q <= 1'b0;
			takeover_dbuv_q <= `TPI_TOP_112;
			gain_detector_off_q <= 1'b0;
			gain_output_hiz_q <= 1'b0;
			gain_fast_source_q <= 1'b0;
		end else begin
			pump_current_sel_q <= loop_control_q[6];
			pump_hiz_q <= (loop_control_q[5:3] == `TPI_TEST_HIZ);
			freq_test_q <= (loop_control_q[5:3] == `TPI_TEST_FREQ);
			ref_ratio_q <= ref_ratio(loop_control_q[2:1]);
			tuning_output_disable_q <= loop_control_q[0];
			high_side_oe_q <= port_switch_q[3:0];
			// Low-side enables are the upper four bits of the port byte
			low_side_oe_q <= port_switch_q[7:4];
			band_sel_q <= band(port_switch_q[1:0]);
			gain_loop_speed_bit_q <= gain_settings_q[7];
			takeover_dbuv_q <= takeover(gain_settings_q[6:4]);
			gain_detector_off_q <= gain_settings_q[6:5] == 2'h3;
			gain_output_hiz_q <= gain_settings_q[6:4] == `TPI_TOP_EXT;
			// External mode releases the pin, so no source current even with the fast bit set
			gain_fast_source_q <= (gain_settings_q[6:4] != `TPI_TOP_EXT) &
				(gain_settings_q[7] | (gain_settings_q[6:4] == `TPI_TOP_OFF));
		end
	end
endmodule

// ===== include/tpi_consts.vh
// Constants for the tuner synthesizer serial programming block
`ifndef TPI_CONSTS_VH
`define TPI_CONSTS_VH
`define TPI_ADDR_FIXED 5'h18
`define TPI_CTRL_RESET 8'hCB
`define TPI_PORT_RESET 8'h00
`define TPI_GAIN_RESET 8'h20
`define TPI_TEST_AUX 3'h3
`define TPI_TEST_HIZ 3'h2
`define TPI_TEST_FREQ 3'h4
`define TPI_TOP_EXT 3'h6
`define TPI_TOP_OFF 3'h7
`define TPI_REF_80 8'h50
`define TPI_REF_128 8'h80
`define TPI_REF_24 8'h18
`define TPI_REF_64 8'h40
`define TPI_TOP_115 8'h73
`define TPI_TOP_112 8'h70
`define TPI_TOP_109 8'h6D
`define TPI_TOP_106 8'h6A
`define TPI_TOP_103 8'h67
`define TPI_ADC_MAX 3'h4
`define TPI_BAND_LOW 2'h1
`define TPI_BAND_MID 2'h2
`define TPI_BAND_HIGH 2'h0
`endif

// ===== rtl/tpi_sync.v
// Two-flop synchroniser with edge detection on the synchronised level
`timescale 1ns/1ps
module tpi_sync (
	input wire mclk,
	input wire reset,
	input wire async_in,
	output reg level_q,
	output reg rise_q,
	output reg fall_q
);
	reg meta_q;
	reg sync_q;

	// First stage read only by second stage
	always @(posedge mclk) begin
		if (reset) begin
			meta_q <= 1'b1;
			sync_q <= 1'b1;
			level_q <= 1'b1;
			rise_q <= 1'b0;
			fall_q <= 1'b0;
		end else begin
			meta_q <= async_in;
			sync_q <= meta_q;
			level_q <= sync_q;
			rise_q <= sync_q & ~level_q;
			fall_q <= ~sync_q & level_q;
		end
	end
endmodule

// ===== verification/tpi_tuner_pll_i2c_asserts.sv
// Checker on the pins of the tuner programming block
`timescale 1ns/1ps
module tpi_tuner_pll_i2c_asserts (
	input wire logic mclk,
	input wire logic reset,
	input wire logic scl_in,
	input wire logic sda_oe_q,
	input wire logic [14:0] divider_ratio_q,
	input wire logic pump_current_sel_q,
	input wire logic [7:0] ref_ratio_q,
	input wire logic [3:0] high_side_oe_q,
	input wire logic [3:0] low_side_oe_q,
	input wire logic [1:0] band_sel_q,
	input wire logic [7:0] takeover_dbuv_q,
	input wire logic gain_detector_off_q,
	input wire logic gain_output_hiz_q,
	input wire logic gain_fast_source_q
);
	default clocking @(posedge mclk); endclocking
	default disable iff (reset);
	////////////////////////////////////////////////////////////////////////////
	// Settings move only while a byte is being acknowledged, never mid-byte
	property p_div; !$stable(divider_ratio_q) |-> sda_oe_q; endproperty
	a_div: assert property (p_div) else $error("divider moved outside ack");
	property p_pump; !$stable(pump_current_sel_q) |-> sda_oe_q; endproperty
	a_pump: assert property (p_pump) else $error("pump moved outside ack");
	property p_port; !$stable({high_side_oe_q, low_side_oe_q}) |-> sda_oe_q; endproperty
	a_port: assert property (p_port) else $error("ports moved outside ack");
	// Data line may only be taken while the bus clock is low
	property p_ack; $rose(sda_oe_q) |-> !scl_in; endproperty
	a_ack: assert property (p_ack) else $error("sda taken with scl high");
	////////////////////////////////////////////////////////////////////////////
	// Decoded settings stay consistent with each other
	property p_ref; ref_ratio_q inside {8'h50, 8'h80, 8'h18, 8'h40}; endproperty
	a_ref: assert property (p_ref) else $error("bad reference ratio");
	property p_band; band_sel_q == (^high_side_oe_q[1:0] ? high_side_oe_q[1:0] : 2'h0); endproperty
	a_band: assert property (p_band) else $error("band does not follow ports");
	property p_top; (takeover_dbuv_q == 8'h00) == gain_detector_off_q; endproperty
	a_top: assert property (p_top) else $error("take-over and detector disagree");
	property p_hiz; gain_output_hiz_q |-> gain_detector_off_q && !gain_fast_source_q; endproperty
	a_hiz: assert property (p_hiz) else $error("gain output not released");
	property p_fast; gain_detector_off_q && !gain_output_hiz_q |-> gain_fast_source_q; endproperty
	a_fast: assert property (p_fast) else $error("fast source missing");
endmodule

// ===== verification/tpi_i2c_master.sv
// Bus master model driving the programming pins
`timescale 1ns/1ps
module tpi_i2c_master (
	input wire logic mclk,
	input wire logic sda_in,
	output logic scl_in,
	output logic sda_drv
);
	// Idle bus: clock stands high, data released to the pull-up
	initial begin
		scl_in = 1'b1;
		sda_drv = 1'b1;
	end
	// Quarter of the 160 ns bus period
	task automatic qw();
		repeat (4) @(negedge mclk);
	endtask
	// Start (1,0,0) or stop (0,1,1): data moves while clock is high
	task automatic cond(input logic a, input logic b, input logic c);
		qw();
		sda_drv <= a;
		qw();
		scl_in <= 1'b1;
		qw();
		sda_drv <= b;
		qw();
		scl_in <= c;
	endtask
	// One bit: data set mid-low, sampled in the middle of the high phase
	task automatic bit_io(input logic b, output logic r);
		qw();
		sda_drv <= b;
		qw();
		scl_in <= 1'b1;
		qw();
		r = sda_in;
		qw();
		scl_in <= 1'b0;
	endtask
	// Whole byte MSB first, then the ack slot released
	task automatic put(input logic [7:0] d, output logic ack);
		for (int i = 7; i >= 0; i--) bit_io(d[i], ack);
		bit_io(1'b1, ack);
	endtask
	task automatic get(input logic ackb, output logic [7:0] d);
		logic r;
		for (int i = 7; i >= 0; i--) bit_io(1'b1, d[i]);
		bit_io(ackb, r);
	endtask
endmodule

// ===== verification/tpi_tuner_pll_i2c_tb.sv
// Self-checking bench for the tuner programming block
`timescale 1ns/1ps
module tpi_tuner_pll_i2c_tb;
	logic mclk, reset, scl_in, sda_in, sda_drv, sda_out_q, sda_oe_q, pll_locked, gain_active, a;
	logic pump_current_sel_q, pump_hiz_q, freq_test_q, tuning_output_disable_q, gain_loop_speed_bit_q;
	logic gain_detector_off_q, gain_output_hiz_q, gain_fast_source_q;
	logic [1:0] address_sel_bits, band_sel_q;
	logic [2:0] adc_level_bits;
	logic [14:0] divider_ratio_q;
	logic [7:0] ref_ratio_q, takeover_dbuv_q, s;
	logic [3:0] high_side_oe_q, low_side_oe_q;
	int n_mismatch = 0, check_count = 0, cyc = 0;
	logic [7:0] rr [4] = '{8'h50, 8'h80, 8'h18, 8'h40};
	logic [7:0] bbt [4] = '{8'h01, 8'h02, 8'h03, 8'hF0};
	logic [2:0] tf [4] = '{3'h0, 3'h1, 3'h2, 3'h4};
	logic [1:0] bnd [4] = '{2'h1, 2'h2, 2'h0, 2'h0};
	logic [7:0] tt [8] = '{8'h73, 8'h73, 8'h70, 8'h6D, 8'h6A, 8'h67, 8'h00, 8'h00};
	// Open-drain data line with pull-up
	assign sda_in = sda_drv & ~(sda_oe_q & ~sda_out_q);
	tpi_i2c_master m (.mclk, .sda_in, .scl_in, .sda_drv);
	tpi_tuner_pll_i2c dut (.mclk, .reset, .scl_in, .sda_in, .sda_out_q, .sda_oe_q, .address_sel_bits,
		.pll_locked, .gain_active, .adc_level_bits, .divider_ratio_q, .pump_current_sel_q, .pump_hiz_q,
		.freq_test_q, .ref_ratio_q, .tuning_output_disable_q, .high_side_oe_q, .low_side_oe_q, .band_sel_q,
		.gain_loop_speed_bit_q, .takeover_dbuv_q, .gain_detector_off_q, .gain_output_hiz_q, .gain_fast_source_q);
	initial begin
		mclk = 1'b0;
		forever #5 mclk = ~mclk;
	end
	////////////////////////////////////////////////////////////////////////////
	task automatic final_report();
		$display("checks %0d mismatches %0d", check_count, n_mismatch);
		if (n_mismatch == 0 && check_count > 0) $display("STATUS OK");
		else $display("STATUS NOT OK");
		$finish;
	endtask
	task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
		check_count++;
		if (seen !== exp) begin
			$display("[FAIL] %s expected %h seen %h", nm, exp, seen);
			n_mismatch++;
		end
	endtask
	// Write telegram of n bytes taken from the top of d
	task automatic wr(input logic [31:0] d, input int n);
		m.cond(1'b1, 1'b0, 1'b0);
		m.put({5'h18, address_sel_bits, 1'b0}, a);
		for (int i = 0; i < n; i++) begin
			m.put(d[31 - 8 * i -: 8], a);
			chk("data ack", a, 1'b0);
		end
		m.cond(1'b0, 1'b1, 1'b1);
	endtask
	task automatic rd(input logic [7:0] e);
		m.cond(1'b1, 1'b0, 1'b0);
		m.put({5'h18, address_sel_bits, 1'b1}, a);
		m.get(1'b1, s);
		m.cond(1'b0, 1'b1, 1'b1);
		chk("status", s, e);
	endtask
	task automatic probe(input logic [7:0] ad, input logic e);
		m.cond(1'b1, 1'b0, 1'b0);
		m.put(ad, a);
		m.cond(1'b0, 1'b1, 1'b1);
		chk("addr ack", a, e);
	endtask
	// Hang guard, well above the expected length of the run
	always @(posedge mclk) begin
		cyc++;
		if (cyc == 40000) begin
			n_mismatch++;
			final_report();
		end
	end
	////////////////////////////////////////////////////////////////////////////
	initial begin
		reset = 1'b1;
		address_sel_bits = 2'h2;
		pll_locked = 1'b0;
		gain_active = 1'b0;
		adc_level_bits = 3'h0;
		repeat (10) @(negedge mclk);
		reset <= 1'b0;
		repeat (10) @(negedge mclk);
		chk("defaults", {pump_current_sel_q, tuning_output_disable_q, pump_hiz_q, freq_test_q, high_side_oe_q,
			low_side_oe_q, band_sel_q, gain_loop_speed_bit_q, gain_detector_off_q}, 16'hC000);
		chk("default take-over", takeover_dbuv_q, 8'h70);
		rd(8'hB0);
		rd(8'h30);
		$display("test reset done");
		for (int i = 0; i < 4; i++) begin
			address_sel_bits = i[1:0];
			probe({5'h18, i[1:0], 1'b0}, 1'b0);
			probe({5'h18, ~i[1], i[0], 1'b0}, 1'b1);
			probe({5'h08, i[1:0], 1'b0}, 1'b1);
		end
		$display("test address done");
		wr({8'h5A, 8'hC3, 16'h0}, 2);
		chk("divider", divider_ratio_q, 15'h5AC3);
		wr({8'h11, 24'h0}, 1);
		chk("half pair", divider_ratio_q, 15'h5AC3);
		wr({8'hC9, 8'h00, 8'h12, 8'h34}, 4);
		chk("divider order", divider_ratio_q, 15'h1234);
		$display("test divider done");
		for (int i = 0; i < 4; i++) begin
			wr({1'b1, i[0], tf[i], i[1:0], i[1], bbt[i], 16'h0}, 2);
			chk("control", {pump_current_sel_q, tuning_output_disable_q, pump_hiz_q, freq_test_q, high_side_oe_q,
				low_side_oe_q, band_sel_q}, {i[0], i[1], tf[i] == 3'h2, tf[i] == 3'h4, bbt[i][3:0], bbt[i][7:4],
				bnd[i]});
			chk("ref ratio", ref_ratio_q, rr[i]);
		end
		for (int k = 0; k < 8; k++) begin
			wr({8'h98, k[0], k[2:0], 4'h0, 16'h0}, 2);
			chk("ports kept", {high_side_oe_q, low_side_oe_q}, 8'h0F);
			chk("take-over", takeover_dbuv_q, tt[k]);
			chk("gain mode", {gain_loop_speed_bit_q, gain_detector_off_q, gain_output_hiz_q},
				{k[0], k > 5, k == 6});
			if (k > 5) chk("fast source", gain_fast_source_q, k == 7);
		end
		wr({8'h98, 8'h20, 8'h88, 8'h05}, 4);
		chk("mixed pairs", {takeover_dbuv_q, high_side_oe_q, band_sel_q}, {8'h70, 4'h5, 2'h1});
		wr({8'h98, 8'hE0, 16'h0}, 2);
		chk("external gain", {gain_output_hiz_q, gain_fast_source_q}, 2'h2);
		$display("test settings done");
		for (int v = 0; v < 5; v++) begin
			pll_locked = v[0];
			gain_active = v[1];
			adc_level_bits = v[2:0];
			repeat (4) @(negedge mclk);
			rd({1'b0, v[0], 2'b11, v[1], v[2:0]});
		end
		// Master ack on a status byte asks for it once more
		m.cond(1'b1, 1'b0, 1'b0);
		m.put({5'h18, address_sel_bits, 1'b1}, a);
		m.get(1'b0, s);
		chk("status first", s, 8'h34);
		m.get(1'b1, s);
		chk("status repeat", s, 8'h34);
		m.cond(1'b0, 1'b1, 1'b1);
		$display("test status done");
		final_report();
	end
endmodule
bind tpi_tuner_pll_i2c tpi_tuner_pll_i2c_asserts u_chk (.mclk, .reset, .scl_in, .sda_oe_q, .divider_ratio_q,
	.pump_current_sel_q, .ref_ratio_q, .high_side_oe_q, .low_side_oe_q, .band_sel_q, .takeover_dbuv_q,
	.gain_detector_off_q, .gain_output_hiz_q, .gain_fast_source_q);
